/* File: logic/spc_pkg.sv */
// package: register map, field layouts, commands and timing of the protocol controller core
package spc_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [7:0] SPC_ADDR_COUNT = 8'h00;
  localparam logic [7:0] SPC_ADDR_FIFO = 8'h04;
  localparam logic [7:0] SPC_ADDR_CMD = 8'h08;
  localparam logic [7:0] SPC_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] SPC_ADDR_INTR = 8'h10;
  localparam logic [7:0] SPC_ADDR_TIMEOUT = 8'h14;
  localparam logic [7:0] SPC_ADDR_FLAGS = 8'h18;
  localparam logic [7:0] SPC_ADDR_CFG1 = 8'h1C;
  localparam logic [7:0] SPC_ADDR_CFG2 = 8'h20;
  localparam logic [7:0] SPC_ADDR_CFG3 = 8'h24;
  localparam logic [7:0] SPC_ADDR_OWNID = 8'h28;
  localparam logic [7:0] SPC_ADDR_COUNTER = 8'h2C;
  // command codes (bit 7 requests dma, low bits select the operation)
  localparam int SPC_CMD_DMA_BIT = 7;
  localparam logic [6:0] SPC_OP_NOP = 7'h00;
  localparam logic [6:0] SPC_OP_RESET = 7'h02;
  localparam logic [6:0] SPC_OP_SELECT = 7'h41;
  localparam logic [6:0] SPC_OP_INIT_XFER = 7'h10;
  localparam logic [6:0] SPC_OP_INIT_DONE = 7'h11;
  localparam logic [6:0] SPC_OP_TGT_XFER = 7'h20;
  localparam logic [6:0] SPC_OP_TGT_DISC = 7'h27;
  // interrupt register bits
  localparam int SPC_INT_DISC = 5;
  localparam int SPC_INT_ILLEGAL = 6;
  // status register bits
  localparam int SPC_STAT_INTR = 7;
  localparam int SPC_STAT_CNT_ZERO = 4;
  // flags register fields: count in bits 4:0, sequence in 7:5
  localparam int SPC_FLAG_CNT_LSB = 0;
  localparam int SPC_FLAG_SEQ_LSB = 5;
  // reset values
  localparam logic [7:0] SPC_RST_BYTE = 8'h00;
  localparam logic [15:0] SPC_RST_COUNT = 16'h0000;
  localparam logic [7:0] SPC_RST_TIMEOUT = 8'h01;
  // timeout unit: one register step lasts this many nanoseconds
  localparam int SPC_TO_STEP_NS = 1000;
  localparam int SPC_CLK_NS = 5;
  localparam int SPC_TO_STEP_CYC = (SPC_TO_STEP_NS + SPC_CLK_NS - 1) / SPC_CLK_NS;
  // ahb encodings
  localparam logic [1:0] SPC_HTRANS_NONSEQ = 2'b10;
  // controller modes
  typedef enum logic [1:0] {SPC_DISC, SPC_SELECTING, SPC_INIT, SPC_TGT} spc_mode_e;
endpackage : spc_pkg

/* File: logic/spc_controller.sv */
// protocol controller core: ahb-lite registers, command decoder, mode tracking, byte fifo, dma counter
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// simple synchronous fifo; one slot is never wasted, count is exact
module spc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronous flush
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
  } spc_fifo_s;
  spc_fifo_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // handshakes; full and empty follow the exact count
  assign in_ready = (st.cnt != DEPTH[AW:0]);
  assign out_valid = (st.cnt != '0);
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;
  assign out_data = mem[st.rd_ptr];
  assign count = st.cnt;

  // pointer and count update, first in first out
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st = '0;
    end else begin
      if (push) next_st.wr_ptr = st.wr_ptr + 1'b1;
      if (pop) next_st.rd_ptr = st.rd_ptr + 1'b1;
      if (push && !pop) next_st.cnt = st.cnt + 1'b1;
      else if (pop && !push) next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end

  // storage carries no reset; the entry at the read pointer is cleared on flush, and a later read sees zero only if that pointer was 0
  always_ff @(posedge clk) begin
    if (flush) mem[st.rd_ptr] <= '0;
    else if (push) mem[st.wr_ptr] <= in_data;
  end
endmodule : spc_fifo

////////////////////////////////////////////////////////////////////////////////

// Operation
// - reset command zeroes command, interrupt, flags, the fifo entry at the read pointer, config 1-3, and status except its counter-zero bit.
// - configuration registers store and return every 8 bit value exactly.
// - after any reset the controller is disconnected, neither initiator nor target.
// - a command from another mode raises the illegal-command interrupt.
// - timeout accepts 1; unanswered select ends in disconnected interrupt, even own id.
// - target disconnect uses the same interrupt as selection timeout.
// - fifo of 16 entries by 9 bits buffers bytes between host and bus.
// - flags register reports exact byte count for every fill level 0 to 16.
// - bytes leave the fifo in the order they were written.
// - host-writable transfer count register feeds the counter of every legal dma command other than reset.
// - dma no-operation copies count into count-down counter, moving no bytes.
// - counter read returns bytes remaining; equals written count after nop load.
module spc_controller
  import spc_pkg::*;
#(
  parameter int FIFO_WIDTH = 9,
  parameter int FIFO_DEPTH = 16,
  parameter int COUNT_BITS = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt request to the host
  output logic irq,
  // bus side of the fifo
  output logic bus_valid,
  input wire logic bus_ready,
  output logic [FIFO_WIDTH-1:0] bus_data,
  // bus side events
  input wire logic sel_response,
  input wire logic target_disconnect,
  input wire logic dma_byte_done
);
  import spc_pkg::*;

  typedef struct packed {
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic [7:0] cmd;
    logic [7:0] intr;
    logic [2:0] seq;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] timeout;
    logic [2:0] own_id;
    logic [COUNT_BITS-1:0] count;
    logic [COUNT_BITS-1:0] counter;
    spc_mode_e mode;
    logic [7:0] to_steps;
    logic [15:0] to_cyc;
  } spc_ctrl_s;
  spc_ctrl_s st, next_st;

  logic wr_fire, rd_fire, cmd_wr, fifo_wr, fifo_rd, cmd_reset;
  logic host_ready, fifo_out_valid, fifo_flush;
  logic [FIFO_WIDTH-1:0] fifo_out;
  logic [$clog2(FIFO_DEPTH):0] fifo_cnt;
  logic [6:0] op;

  // a command is legal only in the mode it belongs to
  function automatic logic cmd_legal(input logic [6:0] code, input spc_mode_e mode);
    logic ok;
    ok = 1'b0;
    case (code)
      SPC_OP_NOP, SPC_OP_RESET: ok = 1'b1;
      SPC_OP_SELECT: ok = (mode == SPC_DISC);
      SPC_OP_INIT_XFER, SPC_OP_INIT_DONE: ok = (mode == SPC_INIT);
      SPC_OP_TGT_XFER, SPC_OP_TGT_DISC: ok = (mode == SPC_TGT);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_legal

  //////////////////////////////////////////////////////////////////////////////
  // data phase decode; the slave never stalls so every access is zero wait
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign irq = (st.intr != '0);
  assign wr_fire = st.a_valid && st.a_write;
  assign cmd_wr = wr_fire && (st.a_addr == SPC_ADDR_CMD);
  assign op = hwdata[6:0];
  assign cmd_reset = cmd_wr && (op == SPC_OP_RESET);
  assign fifo_wr = wr_fire && (st.a_addr == SPC_ADDR_FIFO);
  assign rd_fire = hsel && hready && htrans == SPC_HTRANS_NONSEQ && !hwrite;
  assign fifo_rd = rd_fire && (haddr == SPC_ADDR_FIFO);
  assign fifo_flush = cmd_reset;
  // the host draining a byte wins over the bus side in the same cycle
  assign host_ready = fifo_rd || bus_ready;
  assign bus_valid = fifo_out_valid && !fifo_rd;
  assign bus_data = fifo_out;

  // byte fifo between host and bus
  spc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fifo_flush),
    .in_valid(fifo_wr),
    .in_ready(),
    .in_data({1'b0, hwdata[7:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(host_ready),
    .out_data(fifo_out),
    .count(fifo_cnt)
  );

  // registers, command decode, mode tracking and timers
  always_comb begin
    next_st = st;
    // address phase capture
    next_st.a_valid = hsel && hready && htrans == SPC_HTRANS_NONSEQ;
    next_st.a_write = hwrite;
    next_st.a_addr = haddr;
    // read data is prepared at the address edge and stands through the data phase
    if (rd_fire) begin
      next_st.rdata = '0;
      if (haddr == SPC_ADDR_COUNT) begin
        next_st.rdata[COUNT_BITS-1:0] = st.count;
      end else if (haddr == SPC_ADDR_FIFO) begin
        next_st.rdata[FIFO_WIDTH-1:0] = fifo_out;
      end else if (haddr == SPC_ADDR_CMD) begin
        next_st.rdata[7:0] = st.cmd;
      end else if (haddr == SPC_ADDR_STATUS) begin
        next_st.rdata[SPC_STAT_INTR] = (st.intr != '0);
        next_st.rdata[SPC_STAT_CNT_ZERO] = (st.counter == '0);
        next_st.rdata[1:0] = st.mode;
      end else if (haddr == SPC_ADDR_INTR) begin
        next_st.rdata[7:0] = st.intr;
        next_st.intr = '0;
      end else if (haddr == SPC_ADDR_TIMEOUT) begin
        next_st.rdata[7:0] = st.timeout;
      end else if (haddr == SPC_ADDR_FLAGS) begin
        next_st.rdata[SPC_FLAG_CNT_LSB +: 5] = 5'(fifo_cnt);
        next_st.rdata[SPC_FLAG_SEQ_LSB +: 3] = st.seq;
      end else if (haddr == SPC_ADDR_CFG1) begin
        next_st.rdata[7:0] = st.cfg1;
      end else if (haddr == SPC_ADDR_CFG2) begin
        next_st.rdata[7:0] = st.cfg2;
      end else if (haddr == SPC_ADDR_CFG3) begin
        next_st.rdata[7:0] = st.cfg3;
      end else if (haddr == SPC_ADDR_OWNID) begin
        next_st.rdata[2:0] = st.own_id;
      end else if (haddr == SPC_ADDR_COUNTER) begin
        next_st.rdata[COUNT_BITS-1:0] = st.counter;
      end
    end
    // plain register writes
    if (wr_fire) begin
      if (st.a_addr == SPC_ADDR_COUNT) begin
        next_st.count = hwdata[COUNT_BITS-1:0];
      end else if (st.a_addr == SPC_ADDR_TIMEOUT) begin
        next_st.timeout = hwdata[7:0];
      end else if (st.a_addr == SPC_ADDR_CFG1) begin
        next_st.cfg1 = hwdata[7:0];
      end else if (st.a_addr == SPC_ADDR_CFG2) begin
        next_st.cfg2 = hwdata[7:0];
      end else if (st.a_addr == SPC_ADDR_CFG3) begin
        next_st.cfg3 = hwdata[7:0];
      end else if (st.a_addr == SPC_ADDR_OWNID) begin
        next_st.own_id = hwdata[2:0];
      end
    end
    // dma counter counts down as the bus side moves bytes
    if (dma_byte_done && st.counter != '0) next_st.counter = st.counter - 1'b1;
    // selection timer: steps of the timeout unit, counted in register units
    if (st.mode == SPC_SELECTING) begin
      if (sel_response) begin
        next_st.mode = SPC_INIT;
      end else if (st.to_cyc != '0) begin
        next_st.to_cyc = st.to_cyc - 1'b1;
      end else if (st.to_steps > 8'h01) begin
        next_st.to_steps = st.to_steps - 1'b1;
        next_st.to_cyc = 16'(SPC_TO_STEP_CYC - 1);
      end else begin
        next_st.mode = SPC_DISC;
        next_st.intr[SPC_INT_DISC] = 1'b1;
      end
    end
    // a disconnecting target ends the connection with the timeout interrupt
    if (target_disconnect && st.mode == SPC_INIT) begin
      next_st.mode = SPC_DISC;
      next_st.intr[SPC_INT_DISC] = 1'b1;
    end
    // command register; hardware interrupt sets take priority over the read clear
    if (cmd_wr) begin
      next_st.cmd = hwdata[7:0];
      if (cmd_reset) begin
        next_st.cmd = SPC_RST_BYTE;
        next_st.intr = SPC_RST_BYTE;
        next_st.seq = '0;
        next_st.cfg1 = SPC_RST_BYTE;
        next_st.cfg2 = SPC_RST_BYTE;
        next_st.cfg3 = SPC_RST_BYTE;
        next_st.mode = SPC_DISC;
      end else if (!cmd_legal(op, st.mode)) begin
        next_st.intr[SPC_INT_ILLEGAL] = 1'b1;
      end else begin
        // any legal dma command other than reset loads the counter; a nop moves nothing
        if (hwdata[SPC_CMD_DMA_BIT]) next_st.counter = st.count;
        if (op == SPC_OP_SELECT) begin
          next_st.mode = SPC_SELECTING;
          next_st.seq = 3'h1;
          next_st.to_steps = st.timeout;
          next_st.to_cyc = 16'(SPC_TO_STEP_CYC - 1);
        end else if (op == SPC_OP_INIT_DONE || op == SPC_OP_TGT_DISC) begin
          next_st.mode = SPC_DISC;
        end
      end
    end
  end

  // one register stage for all control state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.timeout <= SPC_RST_TIMEOUT;
      st.count <= SPC_RST_COUNT;
      st.mode <= SPC_DISC;
    end else begin
      st <= next_st;
    end
  end
endmodule : spc_controller

`default_nettype wire

/* File: test/spc_controller_monitor.sv */
// checker: bus, interrupt and fifo head properties seen at the controller ports
`timescale 1ns/1ps
`default_nettype none
module spc_controller_monitor
  import spc_pkg::*;
#(parameter int FIFO_WIDTH = 9) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // interrupt request
  input wire logic irq,
  // fifo link and bus events
  input wire logic bus_valid,
  input wire logic bus_ready,
  input wire logic [FIFO_WIDTH-1:0] bus_data,
  input wire logic sel_response,
  input wire logic target_disconnect,
  input wire logic dma_byte_done
);
  import spc_pkg::*;
  logic rd_go, intr_rd, fifo_rd, cmd_wr, cmd_dp;
  // decoded accepted transfers
  assign rd_go = hsel && hready && htrans == SPC_HTRANS_NONSEQ && !hwrite;
  assign intr_rd = rd_go && haddr == SPC_ADDR_INTR;
  assign fifo_rd = rd_go && haddr == SPC_ADDR_FIFO;
  assign cmd_wr = hsel && hready && htrans == SPC_HTRANS_NONSEQ && hwrite && haddr == SPC_ADDR_CMD;
  // command write data phase: a reset command may clear state at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_dp <= 1'b0;
    else cmd_dp <= cmd_wr;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_no_read; !rd_go; endsequence
  sequence s_no_clear; !intr_rd && !$past(intr_rd) && !cmd_dp && !$past(cmd_dp); endsequence
  property p_ready; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_rst_quiet; disable iff (1'b0) !hresetn |-> !irq && !bus_valid && hrdata == 32'h0; endproperty
  property p_irq_hold; irq ##0 s_no_clear |=> irq; endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(intr_rd) || $past(intr_rd, 2) || $past(cmd_dp) || $past(cmd_dp, 2);
  endproperty
  property p_rd_stand; s_no_read |=> $stable(hrdata); endproperty
  property p_head_hold; bus_valid && !bus_ready && !cmd_dp |=> (bus_valid || fifo_rd) && $stable(bus_data); endproperty
  property p_pop_hide; fifo_rd |-> !bus_valid; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("error response");
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unserviced");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a read");
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  a_head_hold: assert property (p_head_hold) else $error("fifo head moved");
  a_pop_hide: assert property (p_pop_hide) else $error("head offered while popped");
endmodule : spc_controller_monitor

bind spc_controller spc_controller_monitor #(.FIFO_WIDTH(FIFO_WIDTH)) u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .hwrite(hwrite), .hready(hready), .haddr(haddr), .htrans(htrans), .hsize(hsize),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .bus_valid(bus_valid),
  .bus_ready(bus_ready), .bus_data(bus_data), .sel_response(sel_response),
  .target_disconnect(target_disconnect), .dma_byte_done(dma_byte_done));
`default_nettype wire

/* File: test/spc_scsi_side.sv */
// far side model: a target that can stall the fifo link, answer selection and drop off
`timescale 1ns/1ps
`default_nettype none
module spc_scsi_side (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench controls
  input wire logic stall,
  input wire logic answer,
  input wire logic drop,
  input wire logic step,
  // fifo link
  input wire logic bus_valid,
  input wire logic [8:0] bus_data,
  output logic bus_ready,
  // bus events
  output logic sel_response,
  output logic target_disconnect,
  output logic dma_byte_done
);
  logic [8:0] got[$];
  // ready follows the stall request one edge late, like a slow target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bus_ready <= 1'b0;
    else bus_ready <= !stall;
  end
  // record every byte taken so the bench can judge order
  always @(posedge hclk) begin
    if (hresetn && bus_valid && bus_ready) got.push_back(bus_data);
  end
  assign sel_response = answer;
  assign target_disconnect = drop;
  assign dma_byte_done = step;
endmodule : spc_scsi_side
`default_nettype wire

/* File: test/test_scsi_controller_core_checks.sv */
// bench: drives the controller over ahb-lite and judges registers, interrupts, fifo and dma count
`timescale 1ns/1ps
`default_nettype none
module test_scsi_controller_core_checks;
  import spc_pkg::*;
  // reset starts high so that its fall at time zero really triggers the asynchronous clear
  logic hclk = 0, hresetn = 1, hsel = 0, hwrite = 0, stall = 1, answer = 0, drop = 0, step = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, rd;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq, bus_valid, bus_ready, sel_response, target_disconnect, dma_byte_done;
  wire logic [8:0] bus_data;
  int fail_count = 0, num_checks = 0;
  always #2.5 hclk = ~hclk;
  spc_controller #(.FIFO_WIDTH(9), .FIFO_DEPTH(16), .COUNT_BITS(16)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_data(bus_data), .sel_response(sel_response),
    .target_disconnect(target_disconnect), .dma_byte_done(dma_byte_done));
  spc_scsi_side far (.hclk(hclk), .hresetn(hresetn), .stall(stall), .answer(answer), .drop(drop),
    .step(step), .bus_valid(bus_valid), .bus_data(bus_data), .bus_ready(bus_ready),
    .sel_response(sel_response), .target_disconnect(target_disconnect), .dma_byte_done(dma_byte_done));
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    num_checks++;
    if ((got & msk) !== (exp & msk)) begin
      fail_count++;
      $display("mismatch %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for hready at a rising edge; a hang ends the run
  task edge_ready;
    for (int n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    fail_count++;
    results();
  endtask : edge_ready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= SPC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    rd = hrdata;
  endtask : ahb
  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, msk);
  endtask : rchk
  // irq polled at the falling edge where it is settled
  task wait_irq(input int lim);
    for (int n = 0; n < lim; n++) begin
      @(negedge hclk);
      if (irq === 1'b1) begin
        @(posedge hclk);
        return;
      end
    end
    fail_count++;
    results();
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [7:0] zr[7] = '{SPC_ADDR_CMD, SPC_ADDR_INTR, SPC_ADDR_FLAGS, SPC_ADDR_CFG1, SPC_ADDR_CFG2,
      SPC_ADDR_CFG3, SPC_ADDR_FIFO};
    ahb(1, SPC_ADDR_CFG1, 32'hA5);
    ahb(1, SPC_ADDR_CFG2, 32'h5A);
    ahb(1, SPC_ADDR_CFG3, 32'h3C);
    ahb(1, SPC_ADDR_FIFO, 32'h77);
    ahb(1, SPC_ADDR_CMD, SPC_OP_RESET);
    foreach (zr[i]) rchk(zr[i], 32'h0, 32'hFF);
    rchk(SPC_ADDR_STATUS, 32'h0, 32'h83);
    rchk(8'h3C, 32'h0, 32'hFFFFFFFF);
  endtask : t_reset
  task t_cfg;
    for (int v = 0; v < 256; v++) begin
      ahb(1, SPC_ADDR_CFG1, v);
      ahb(1, SPC_ADDR_CFG2, 255 - v);
      ahb(1, SPC_ADDR_CFG3, v);
      rchk(SPC_ADDR_CFG1, v, 32'hFF);
      rchk(SPC_ADDR_CFG2, 255 - v, 32'hFF);
      rchk(SPC_ADDR_CFG3, v, 32'hFF);
    end
  endtask : t_cfg
  task t_illegal;
    logic [6:0] ops[4] = '{SPC_OP_INIT_XFER, SPC_OP_INIT_DONE, SPC_OP_TGT_XFER, SPC_OP_TGT_DISC};
    foreach (ops[i]) begin
      ahb(1, SPC_ADDR_CMD, SPC_OP_RESET);
      ahb(1, SPC_ADDR_CMD, ops[i]);
      wait_irq(20);
      repeat (5) @(negedge hclk);
      chk(irq, 1, 1);
      @(posedge hclk);
      rchk(SPC_ADDR_INTR, 32'h1 << SPC_INT_ILLEGAL, 32'h1 << SPC_INT_ILLEGAL);
      @(negedge hclk);
      chk(irq, 0, 1);
      @(posedge hclk);
    end
  endtask : t_illegal
  task t_timeout;
    ahb(1, SPC_ADDR_CMD, SPC_OP_RESET);
    ahb(1, SPC_ADDR_TIMEOUT, 32'h1);
    ahb(1, SPC_ADDR_OWNID, 32'h7);
    ahb(1, SPC_ADDR_CMD, SPC_OP_SELECT);
    wait_irq(600);
    rchk(SPC_ADDR_INTR, 32'h1 << SPC_INT_DISC, 32'h1 << SPC_INT_DISC);
    rchk(SPC_ADDR_STATUS, 32'h0, 32'h3);
  endtask : t_timeout
  task t_disc;
    ahb(1, SPC_ADDR_CMD, SPC_OP_RESET);
    answer <= 1'b1;
    ahb(1, SPC_ADDR_CMD, SPC_OP_SELECT);
    // the answer is only seen once the mode reads selecting, one edge after the command lands
    @(posedge hclk);
    rchk(SPC_ADDR_STATUS, 32'h2, 32'h3);
    answer <= 1'b0;
    drop <= 1'b1;
    @(posedge hclk);
    drop <= 1'b0;
    wait_irq(20);
    rchk(SPC_ADDR_INTR, 32'h1 << SPC_INT_DISC, 32'h1 << SPC_INT_DISC);
  endtask : t_disc
  task t_fifo;
    ahb(1, SPC_ADDR_CMD, SPC_OP_RESET);
    for (int k = 0; k < 16; k++) begin
      rchk(SPC_ADDR_FLAGS, k, 32'h1F);
      ahb(1, SPC_ADDR_FIFO, 32'h30 + k);
    end
    rchk(SPC_ADDR_FLAGS, 32'd16, 32'h1F);
    rchk(SPC_ADDR_FIFO, 32'h30, 32'hFF);
    rchk(SPC_ADDR_FIFO, 32'h31, 32'hFF);
    stall <= 1'b0;
    for (int n = 0; n < 60 && far.got.size() < 14; n++) @(posedge hclk);
    stall <= 1'b1;
    chk(far.got.size(), 32'd14, 32'hFF);
    foreach (far.got[i]) chk(far.got[i], 32'h32 + i, 32'h1FF);
    rchk(SPC_ADDR_FLAGS, 32'h0, 32'h1F);
  endtask : t_fifo
  task t_dma;
    logic [15:0] vals[4] = '{16'h0000, 16'h0001, 16'h8000, 16'hFFFF};
    foreach (vals[i]) begin
      ahb(1, SPC_ADDR_COUNT, vals[i]);
      ahb(1, SPC_ADDR_CMD, 32'h80 | SPC_OP_NOP);
      rchk(SPC_ADDR_COUNTER, vals[i], 32'hFFFF);
      rchk(SPC_ADDR_FLAGS, 32'h0, 32'h1F);
      if (vals[i] != 16'h0) begin
        step <= 1'b1;
        @(posedge hclk);
        step <= 1'b0;
        rchk(SPC_ADDR_COUNTER, vals[i] - 16'h1, 32'hFFFF);
      end
    end
  endtask : t_dma
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_cfg();
    t_illegal();
    t_timeout();
    t_disc();
    t_fifo();
    t_dma();
    results();
  end
endmodule : test_scsi_controller_core_checks
`default_nettype wire
